/* File: src/hpw_write_port.sv */
// Purpose: Write side of the strobe-framed asynchronous 16-bit host port.
// Assumes: Host pins are asynchronous to clock and pass two flip-flops first.
// Notes:   A write is delivered as a one-cycle pulse after the cycle ends.
//
// What this block does
// - Every host write uses the cycle framed by select and write strobe, both low.
// - A cycle starts only when select and write strobe are both low, in any order.
// - A cycle ends as soon as select or strobe or both go high, in any order.
// - Data is the last word sampled while both are low, so it must be steady one 8 ns clock before the edge that ends the cycle.
// - With fifo select high the upper address is ignored and the word goes to the TX FIFO.
// - FIFO-direct writes use the ordinary timing, fifo select timed like the address.
// - Each write cycle moves one 16-bit word.
`timescale 1ns/1ps
`default_nettype none
`include "hpw_map.svh"

module hpw_write_port #(
   parameter int DATA_W = `HPW_DATA_W,
   parameter int ADDR_W = `HPW_ADDR_W
) (
   input  wire logic                clock,
   input  wire logic                reset_n,
   input  wire logic                host_select_low,
   input  wire logic                write_strobe_low,
   input  wire logic                fifo_sel,
   input  wire logic [ADDR_W-1:0]   host_addr,
   input  wire logic [DATA_W-1:0]   host_data,
   output var  logic                reg_write_q,
   output var  logic [ADDR_W-1:0]   reg_addr_q,
   output var  logic                fifo_push_q,
   output var  logic [DATA_W-1:0]   wr_data_q,
   output var  logic                cycle_active_q
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // The carrier struct takes its widths from the map, so other widths cannot be served
   if (DATA_W != `HPW_DATA_W || ADDR_W != `HPW_ADDR_W) begin : g_width_check
      $error("hpw_write_port: unsupported width");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic                 cs_m_q,   cs_s_q;
   logic                 wr_m_q,   wr_s_q;
   logic                 fs_m_q,   fs_s_q;
   logic [ADDR_W-1:0]    ad_m_q,   ad_s_q;
   logic [DATA_W-1:0]    dt_m_q,   dt_s_q;

   // Idle high so reset never fakes a cycle start
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         cs_m_q <= 1'b1;
         cs_s_q <= 1'b1;
         wr_m_q <= 1'b1;
         wr_s_q <= 1'b1;
      end else begin
         cs_m_q <= host_select_low;
         cs_s_q <= cs_m_q;
         wr_m_q <= write_strobe_low;
         wr_s_q <= wr_m_q;
      end
   end

   // Address, select and data follow the strobes through equal depth
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         fs_m_q <= 1'b0;
         fs_s_q <= 1'b0;
         ad_m_q <= '0;
         ad_s_q <= '0;
         dt_m_q <= '0;
         dt_s_q <= '0;
      end else begin
         fs_m_q <= fifo_sel;
         fs_s_q <= fs_m_q;
         ad_m_q <= host_addr;
         ad_s_q <= ad_m_q;
         dt_m_q <= host_data;
         dt_s_q <= dt_m_q;
      end
   end

   // ----------------------------------------------------------------
   // Cycle framing
   // ----------------------------------------------------------------
   logic                 both_low;
   hpw_pkg::hpw_state_e  state_q;
   hpw_pkg::hpw_write_s  held_q;
   logic                 done_q;

   assign both_low = !cs_s_q && !wr_s_q;

   // Start needs both low; end on either high, so order never matters
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_q <= hpw_pkg::HPW_IDLE;
      end else begin
         case (state_q)
            hpw_pkg::HPW_IDLE: begin
               if (both_low) begin
                  state_q <= hpw_pkg::HPW_ACTIVE;
               end
            end
            hpw_pkg::HPW_ACTIVE: begin
               if (!both_low) begin
                  state_q <= hpw_pkg::HPW_RECOVER;
               end
            end
            hpw_pkg::HPW_RECOVER: begin
               // Back-to-back cycles: a fresh assertion is seen here too
               state_q <= both_low ? hpw_pkg::HPW_ACTIVE : hpw_pkg::HPW_IDLE;
            end
            default: begin
               state_q <= hpw_pkg::HPW_IDLE;
            end
         endcase
      end
   end

   // Track the last sample during the cycle; the one before deassertion wins
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         held_q <= '0;
      end else if (both_low) begin
         held_q.to_fifo <= fs_s_q;
         held_q.addr    <= ad_s_q;
         held_q.data    <= dt_s_q;
      end
   end

   // One pulse per ended cycle
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         done_q <= 1'b0;
      end else begin
         done_q <= (state_q == hpw_pkg::HPW_ACTIVE) && !both_low;
      end
   end

   // ----------------------------------------------------------------
   // Routing of the written word
   // ----------------------------------------------------------------
   // Low address lines stay visible so the FIFO port keeps its lane
   function automatic logic [ADDR_W-1:0] fifo_addr(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] r;
      r = ADDR_W'(`HPW_TXFIFO_WIN);
      r[`HPW_LOW_ADDR_MSB:`HPW_LOW_ADDR_LSB] = a[`HPW_LOW_ADDR_MSB:`HPW_LOW_ADDR_LSB];
      return r;
   endfunction : fifo_addr

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         reg_write_q <= 1'b0;
         fifo_push_q <= 1'b0;
         reg_addr_q  <= '0;
         wr_data_q   <= `HPW_RESET_WORD;
      end else begin
         fifo_push_q <= done_q && held_q.to_fifo;
         reg_write_q <= done_q && !held_q.to_fifo;
         if (done_q) begin
            reg_addr_q <= held_q.to_fifo ? fifo_addr(held_q.addr) : held_q.addr;
            wr_data_q  <= held_q.data;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         cycle_active_q <= 1'b0;
      end else begin
         cycle_active_q <= both_low;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   start_needs_both_a: assert property (
      $rose(state_q == hpw_pkg::HPW_ACTIVE) |-> $past(both_low))
      else $error("cycle started without both strobes low");

   end_on_either_a: assert property (
      (state_q == hpw_pkg::HPW_ACTIVE && !both_low) |=> ##1 (reg_write_q || fifo_push_q))
      else $error("ended cycle produced no write");

   fifo_route_a: assert property (
      (done_q && held_q.to_fifo) |=> fifo_push_q && !reg_write_q
         && reg_addr_q[ADDR_W-1:3] == (ADDR_W-3)'(ADDR_W'(`HPW_TXFIFO_WIN) >> 3))
      else $error("fifo-direct write misrouted");

   reg_route_a: assert property (
      (done_q && !held_q.to_fifo) |=> reg_write_q && reg_addr_q == $past(held_q.addr))
      else $error("register write misrouted");

   data_capture_a: assert property (
      done_q |=> wr_data_q == $past(held_q.data))
      else $error("write data not the last sampled word");

   single_pulse_a: assert property (
      (reg_write_q || fifo_push_q) |=> !(reg_write_q || fifo_push_q))
      else $error("write pulse longer than one cycle");

   exclusive_out_a: assert property (
      !(reg_write_q && fifo_push_q))
      else $error("register and fifo written together");

   no_write_idle_a: assert property (
      (state_q == hpw_pkg::HPW_IDLE) |-> !done_q)
      else $error("write from idle state");

   cov_reg_write_c:  cover property (reg_write_q);
   cov_fifo_push_c:  cover property (fifo_push_q);
   cov_back2back_c:  cover property (fifo_push_q ##[1:12] fifo_push_q);
   cov_recover_c:    cover property (state_q == hpw_pkg::HPW_RECOVER && both_low);

endmodule : hpw_write_port
`default_nettype wire

/* File: src/hpw_map.svh */
// Purpose: Constants of the host write port: widths, address fields, timing.
// Assumes: Included by bare name; definitions only.
// Notes:   Times in ns; cycle counts derive from the 125 MHz clock.
`ifndef HPW_MAP_SVH
`define HPW_MAP_SVH

// ----------------------------------------------------------------
// Widths and address fields
// ----------------------------------------------------------------
`define HPW_DATA_W        16
`define HPW_ADDR_W        8
`define HPW_LOW_ADDR_MSB  2
`define HPW_LOW_ADDR_LSB  1
`define HPW_TXFIFO_WIN    8'h20
`define HPW_RESET_WORD    16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HPW_CLK_PERIOD_NS 8
`define HPW_CSH_MIN_NS    13
`define HPW_CSL_MIN_NS    32
`define HPW_CYCLE_MIN_NS  45
`define HPW_DSU_MIN_NS    7
`define HPW_CSH_CYC ((`HPW_CSH_MIN_NS + `HPW_CLK_PERIOD_NS - 1) / `HPW_CLK_PERIOD_NS)
`define HPW_CSL_CYC ((`HPW_CSL_MIN_NS + `HPW_CLK_PERIOD_NS - 1) / `HPW_CLK_PERIOD_NS)

`endif

/* File: src/hpw_pkg.sv */
// Purpose: Types of the host write port.
// Assumes: hpw_map.svh supplies the widths.
// Notes:   No constants live here; they sit in the map header.
`default_nettype none
`include "hpw_map.svh"

package hpw_pkg;

   // Write port state machine
   typedef enum logic [1:0] {
      HPW_IDLE,
      HPW_ACTIVE,
      HPW_RECOVER
   } hpw_state_e;

   // One decoded write handed to the internal logic
   typedef struct packed {
      logic                       to_fifo;
      logic [`HPW_ADDR_W-1:0]     addr;
      logic [`HPW_DATA_W-1:0]     data;
   } hpw_write_s;

endpackage : hpw_pkg
`default_nettype wire

/* File: testbench/hpw_host_model.sv */
// Purpose: Host side of the write port: strobe-framed 16-bit write cycles.
// Assumes: Pins change at the falling edge of clock.
// Notes:   The data bus shows the inverse word outside the valid window.
`timescale 1ns/1ps
`default_nettype none

module hpw_host_model (
   input  wire logic        clock,
   output var  logic        host_select_low,
   output var  logic        write_strobe_low,
   output var  logic        fifo_sel,
   output var  logic [7:0]  host_addr,
   output var  logic [15:0] host_data
);
   // ---------------------------------------------------------------
   // Idle pins
   // ---------------------------------------------------------------
   initial begin
      host_select_low  = 1'b1;
      write_strobe_low = 1'b1;
      fifo_sel         = 1'b0;
      host_addr        = 8'h00;
      host_data        = 16'hffff;
   end

   // One write; ord[0] lowers strobe first, ord[1] raises strobe first
   task automatic write(input logic [8:0] a, input logic [15:0] d, input logic [1:0] ord);
      @(negedge clock);
      host_addr <= a[7:0];
      fifo_sel  <= a[8];
      host_data <= ~d;
      if (ord[0]) write_strobe_low <= 1'b0;
      else host_select_low <= 1'b0;
      @(negedge clock);
      write_strobe_low <= 1'b0;
      host_select_low  <= 1'b0;
      @(negedge clock);
      host_data <= d;                                    // Steady three cycles before the end
      repeat (3) @(negedge clock);                       // Assertion lasts 32 ns
      if (ord[1]) write_strobe_low <= 1'b1;
      else host_select_low <= 1'b1;
      @(negedge clock);
      write_strobe_low <= 1'b1;
      host_select_low  <= 1'b1;
      host_data        <= ~d;
      repeat (2) @(negedge clock);                       // Strobes stay high far beyond 13 ns
   endtask : write

   // Select alone, strobe high: never a cycle
   task automatic select_only();
      @(negedge clock);
      host_select_low <= 1'b0;
      repeat (5) @(negedge clock);
      host_select_low <= 1'b1;
      repeat (2) @(negedge clock);
   endtask : select_only
endmodule : hpw_host_model

`default_nettype wire

/* File: testbench/hpw_write_port_bench.sv */
// Purpose: Self-checking bench of the host write port against a queue model.
// Assumes: Write pulse four edges after the pins end the cycle.
// Notes:   Random words from an LFSR; all strobe orders and both routes.
`timescale 1ns/1ps
`default_nettype none
`include "hpw_map.svh"

module hpw_write_port_bench;
   logic clock, reset_n, sel_n, str_n, fsel, rw, fp, act, low_p;
   logic [7:0] addr, raddr;
   logic [15:0] data, wdata;
   logic [24:0] exp_q[$];
   logic [24:0] e, nxt;
   logic [31:0] r;
   int errors, checks, lowcnt;
   int age = -1;

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   hpw_host_model host (.clock(clock), .host_select_low(sel_n), .write_strobe_low(str_n),
      .fifo_sel(fsel), .host_addr(addr), .host_data(data));
   hpw_write_port DUT (.clock(clock), .reset_n(reset_n), .host_select_low(sel_n),
      .write_strobe_low(str_n), .fifo_sel(fsel), .host_addr(addr), .host_data(data),
      .reg_write_q(rw), .reg_addr_q(raddr), .fifo_push_q(fp), .wr_data_q(wdata), .cycle_active_q(act));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
   endfunction : lfsr

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      if (errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results

   // Monitor after each edge has settled; age counts edges since the cycle ended
   always @(posedge clock) begin
      #1;
      low_p = !sel_n && !str_n;
      // First edge that sees the pins out of a cycle counts as edge one after its end
      if (!low_p && lowcnt > 0) age = 1;
      else if (age >= 0) age++;
      lowcnt = low_p ? lowcnt + 1 : 0;
      if (lowcnt == 4) check(32'(act), 32'h1);
      if (age == 4) check(32'(act), 32'h0);
      if (rw || fp) begin
         if (exp_q.size() == 0) check(32'h1, 32'h0);
         else begin
            e = exp_q.pop_front();
            check(32'(age), 32'h4);
            check({30'h0, fp, rw}, {30'h0, e[24], !e[24]});
            check(32'(raddr), 32'(e[23:16]));
            check(32'(wdata), 32'(e[15:0]));
         end
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      r = 32'ha7cdeb2d;
      repeat (6) @(negedge clock);
      reset_n <= 1'b1;
      repeat (2) @(negedge clock);
      for (int i = 0; i < 16; i++) begin
         r = lfsr(r);
         nxt[24] = i[2];
         nxt[23:16] = i[2] ? (`HPW_TXFIFO_WIN | {5'h0, r[2:1], 1'b0}) : r[7:0];
         nxt[15:0] = r[31:16];
         exp_q.push_back(nxt);
         host.write({i[2], r[7:0]}, r[31:16], i[1:0]);
         if (i == 9) host.select_only();
      end
      for (int k = 0; k < 50 && exp_q.size() > 0; k++) @(negedge clock);
      check(32'(exp_q.size()), 32'h0);
      repeat (8) @(negedge clock);
      results();
   end
endmodule : hpw_write_port_bench

`default_nettype wire
